// ===== hdl/spm_pkg.sv
// Constants, register map and state encoding of the sensor PLL and mode control block
package spm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE_CTRL  = 8'h00;
  localparam logic [7:0] OFS_TRIG_CTRL  = 8'h04;
  localparam logic [7:0] OFS_PIN_SEL    = 8'h08;
  localparam logic [7:0] OFS_PLL_MUL    = 8'h0c;
  localparam logic [7:0] OFS_PRE_DIV    = 8'h10;
  localparam logic [7:0] OFS_PIX_DIV    = 8'h14;
  localparam logic [7:0] OFS_ROW_RATE   = 8'h18;
  localparam logic [7:0] OFS_STATUS     = 8'h1c;
  localparam logic [7:0] OFS_LIM_MUL    = 8'h20;
  localparam logic [7:0] OFS_LIM_PRE    = 8'h24;
  localparam logic [7:0] OFS_LIM_VCO    = 8'h28;
  localparam logic [7:0] OFS_LIM_VCOIN  = 8'h2c;
  localparam logic [7:0] OFS_SYS_DIV    = 8'h30;
  localparam logic [7:0] OFS_GPI_STATUS = 8'h34;
  // Field positions
  localparam int STREAM_BIT    = 2;
  localparam int GPI_EN_BIT    = 8;
  localparam int TRIG_BIT      = 0;
  localparam int GRST_EN_BIT   = 1;
  localparam int SEL_STBY_LSB  = 0;
  localparam int SEL_TRIG_LSB  = 4;
  localparam int PIX_OP_LSB    = 8;
  localparam int ROW_OP_LSB    = 8;
  // Reset values: serial interface defaults; fixed system dividers read back at OFS_SYS_DIV
  localparam logic [7:0]  RST_PLL_MUL   = 8'h40;
  localparam logic [5:0]  RST_PRE_DIV   = 6'h01;
  localparam logic [4:0]  RST_ARR_DIV   = 5'h03;
  localparam logic [4:0]  RST_OUT_DIV   = 5'h0c;
  localparam logic [2:0]  RST_ROW_LO    = 3'h1;
  localparam logic [2:0]  RST_ROW_HI    = 3'h1;
  localparam logic [3:0]  ARR_SYS_DIV   = 4'h1;
  localparam logic [3:0]  OUT_SYS_DIV   = 4'hc;
  // Limits reported read-only
  localparam logic [7:0]  MUL_MIN       = 8'h20;
  localparam logic [7:0]  MUL_MAX       = 8'h80;
  localparam logic [7:0]  PRE_MIN       = 8'h00;
  localparam logic [7:0]  PRE_MAX       = 8'h3f;
  localparam logic [15:0] VCO_MIN_MHZ   = 16'h0180;
  localparam logic [15:0] VCO_MAX_MHZ   = 16'h0300;
  localparam logic [15:0] VIN_MIN_MHZ   = 16'h0006;
  localparam logic [15:0] VIN_MAX_MHZ   = 16'h0030;
  // Timing
  localparam int CLK_MHZ        = 25;
  localparam int LOCK_TIME_US   = 1000;
  localparam int LOCK_CYCLES    = LOCK_TIME_US * CLK_MHZ;
  localparam int NO_PIN         = 0;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_LOCK    = 2'b01,
    ST_STREAM  = 2'b10,
    ST_WAITEND = 2'b11
  } spm_state_type;
endpackage

// ===== hdl/spm_gpi_if.sv
// Interface carrying synchronised general purpose inputs and pin selections
`timescale 1ns/100ps
interface spm_gpi_if;
  logic [3:0] gpi_sync;
  logic [2:0] sel_stby;
  logic [2:0] sel_trig;
  logic       stby_pin;
  logic       stby_pin_used;
  logic       trig_pin;
  logic       trig_pin_used;
  modport sync (output gpi_sync);
  modport sel  (input gpi_sync, input sel_stby, input sel_trig,
                output stby_pin, output stby_pin_used, output trig_pin, output trig_pin_used);
  modport top  (input gpi_sync, output sel_stby, output sel_trig,
                input stby_pin, input stby_pin_used, input trig_pin, input trig_pin_used);
endinterface

// ===== hdl/spm_gpi_sync.sv
// Two-stage synchroniser for general purpose input pins
`timescale 1ns/100ps
module spm_gpi_sync #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] gpi_pin,
  spm_gpi_if.sync           gif
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spm_sync_type;
  spm_sync_type st_ff, nxt_st;
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = gpi_pin;
    nxt_st.s2 = st_ff.s1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign gif.gpi_sync = st_ff.s2;
endmodule

// ===== hdl/spm_gpi_select.sv
// Maps a selected general purpose input onto the standby and trigger functions
`timescale 1ns/100ps
module spm_gpi_select (
  spm_gpi_if.sel gif
);
  // Code 0 means unassigned, codes 1..4 select an input
  function automatic logic pick(input logic [3:0] v, input logic [2:0] s);
    logic r;
    r = 1'b0;
    if (s != 3'h0 && s <= 3'h4) begin
      r = v[s[1:0] - 2'h1];
    end
    return r;
  endfunction
  function automatic logic used(input logic [2:0] s);
    return (s != 3'h0 && s <= 3'h4);
  endfunction
  assign gif.stby_pin      = pick(gif.gpi_sync, gif.sel_stby);
  assign gif.stby_pin_used = used(gif.sel_stby);
  assign gif.trig_pin      = pick(gif.gpi_sync, gif.sel_trig);
  assign gif.trig_pin_used = used(gif.sel_trig);
endmodule

// ===== hdl/spm_top.sv
// Streaming, standby, trigger and PLL divider control with APB register access
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/100ps
module spm_top #(
  parameter int LOCK_CYC = spm_pkg::LOCK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  gpi_pin,
  input  wire logic        frame_end,
  output logic             pll_enable,
  output logic             pll_out_connect,
  output logic             core_clk_gate,
  output logic             grst_start,
  output logic [7:0]       pll_multiplier,
  output logic [5:0]       prescale_field,
  output logic [4:0]       array_pixel_divider,
  output logic [4:0]       output_pixel_divider,
  output logic [2:0]       row_rate_arr,
  output logic [2:0]       row_rate_out
);
  import spm_pkg::*;

  typedef struct packed {
    spm_state_type state;
    logic [24:0]   lock_cnt;
    logic          stream_bit;
    logic          gpi_en;
    logic          trig_bit;
    logic          grst_en;
    logic [2:0]    sel_stby;
    logic [2:0]    sel_trig;
    logic [7:0]    mul;
    logic [5:0]    pre;
    logic [4:0]    arr_div;
    logic [4:0]    out_div;
    logic [2:0]    row_lo;
    logic [2:0]    row_hi;
    logic          trig_prev;
    logic          grst_start;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          pll_en;
    logic          pll_conn;
    logic          clk_gate;
  } spm_regs_type;

  spm_regs_type r_ff, nxt_r;
  spm_gpi_if gif();

  logic want_stream;
  logic trig_level;
  logic apb_setup;
  logic apb_wr;
  logic apb_rd;
  logic [31:0] rd_val;
  logic        rd_err;

  spm_gpi_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .gpi_pin (gpi_pin),
    .gif     (gif.sync)
  );
  spm_gpi_select u_sel (
    .gif (gif.sel)
  );

  assign gif.sel_stby = r_ff.gpi_en ? r_ff.sel_stby : 3'h0;
  assign gif.sel_trig = r_ff.gpi_en ? r_ff.sel_trig : 3'h0;

  // Pin high forces standby; with no pin the bit alone decides
  always_comb begin
    if (gif.stby_pin_used) begin
      want_stream = r_ff.stream_bit && !gif.stby_pin;
    end else begin
      want_stream = r_ff.stream_bit;
    end
    trig_level = r_ff.trig_bit || (gif.trig_pin_used && gif.trig_pin);
  end

  // Slave answers in the access phase with no wait states
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign apb_rd    = apb_setup && !pwrite;

  always_comb begin
    rd_val = 32'h0;
    rd_err = 1'b0;
    unique case (paddr)
      OFS_MODE_CTRL:  rd_val = {23'h0, r_ff.gpi_en, 5'h0, r_ff.stream_bit, 2'h0};
      OFS_TRIG_CTRL:  rd_val = {30'h0, r_ff.grst_en, r_ff.trig_bit};
      OFS_PIN_SEL:    rd_val = {25'h0, r_ff.sel_trig, 1'b0, r_ff.sel_stby};
      OFS_PLL_MUL:    rd_val = {24'h0, r_ff.mul};
      OFS_PRE_DIV:    rd_val = {26'h0, r_ff.pre};
      OFS_PIX_DIV:    rd_val = {19'h0, r_ff.out_div, 3'h0, r_ff.arr_div};
      OFS_ROW_RATE:   rd_val = {21'h0, r_ff.row_hi, 5'h0, r_ff.row_lo};
      OFS_STATUS:     rd_val = {27'h0, r_ff.clk_gate, r_ff.pll_conn, r_ff.pll_en, r_ff.state};
      OFS_LIM_MUL:    rd_val = {16'h0, MUL_MAX, MUL_MIN};
      OFS_LIM_PRE:    rd_val = {16'h0, PRE_MAX, PRE_MIN};
      OFS_LIM_VCO:    rd_val = {VCO_MAX_MHZ, VCO_MIN_MHZ};
      OFS_LIM_VCOIN:  rd_val = {VIN_MAX_MHZ, VIN_MIN_MHZ};
      OFS_SYS_DIV:    rd_val = {24'h0, OUT_SYS_DIV, ARR_SYS_DIV};
      OFS_GPI_STATUS: rd_val = {28'h0, gif.gpi_sync};
      default:        rd_err = 1'b1;
    endcase
  end

  always_comb begin
    nxt_r            = r_ff;
    nxt_r.grst_start = 1'b0;
    nxt_r.pready     = apb_setup;
    nxt_r.pslverr    = apb_setup && rd_err;
    if (apb_rd) begin
      nxt_r.prdata = rd_val;
    end
    // Register writes stay live in every state so software can always reach the block
    if (apb_wr) begin
      unique case (paddr)
        OFS_MODE_CTRL: begin
          nxt_r.stream_bit = pwdata[STREAM_BIT];
          nxt_r.gpi_en     = pwdata[GPI_EN_BIT];
        end
        OFS_TRIG_CTRL: begin
          nxt_r.trig_bit = pwdata[TRIG_BIT];
          nxt_r.grst_en  = pwdata[GRST_EN_BIT];
        end
        OFS_PIN_SEL: begin
          nxt_r.sel_stby = pwdata[SEL_STBY_LSB +: 3];
          nxt_r.sel_trig = pwdata[SEL_TRIG_LSB +: 3];
        end
        // Divider writes during streaming are undefined for the host; stored as given
        OFS_PLL_MUL:   nxt_r.mul = pwdata[7:0];
        OFS_PRE_DIV:   nxt_r.pre = pwdata[5:0];
        OFS_PIX_DIV: begin
          nxt_r.arr_div = pwdata[4:0];
          nxt_r.out_div = pwdata[PIX_OP_LSB +: 5];
        end
        OFS_ROW_RATE: begin
          nxt_r.row_lo = pwdata[2:0];
          nxt_r.row_hi = pwdata[ROW_OP_LSB +: 3];
        end
        default: ;
      endcase
    end

    // Global reset trigger fires on the rising level of bit or pin
    nxt_r.trig_prev = trig_level;
    if (r_ff.grst_en && trig_level && !r_ff.trig_prev) begin
      nxt_r.grst_start = 1'b1;
    end

    unique case (r_ff.state)
      ST_STANDBY: begin
        nxt_r.pll_en   = 1'b0;
        nxt_r.pll_conn = 1'b0;
        nxt_r.clk_gate = 1'b0;
        if (want_stream) begin
          nxt_r.state    = ST_LOCK;
          nxt_r.pll_en   = 1'b1;
          nxt_r.lock_cnt = '0;
        end
      end
      ST_LOCK: begin
        // Output stays bypassed for the worst case lock time, not the typical one
        nxt_r.lock_cnt = r_ff.lock_cnt + 25'h1;
        if (!want_stream) begin
          nxt_r.state  = ST_STANDBY;
          nxt_r.pll_en = 1'b0;
        end else if (r_ff.lock_cnt >= 25'(LOCK_CYC - 1)) begin
          nxt_r.state    = ST_STREAM;
          nxt_r.pll_conn = 1'b1;
          nxt_r.clk_gate = 1'b1;
        end
      end
      ST_STREAM: begin
        if (!want_stream) begin
          nxt_r.state = ST_WAITEND;
        end
      end
      ST_WAITEND: begin
        if (frame_end) begin
          nxt_r.state    = ST_STANDBY;
          nxt_r.pll_en   = 1'b0;
          nxt_r.pll_conn = 1'b0;
          nxt_r.clk_gate = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff         <= '0;
      r_ff.state   <= ST_STANDBY;
      r_ff.mul     <= RST_PLL_MUL;
      r_ff.pre     <= RST_PRE_DIV;
      r_ff.arr_div <= RST_ARR_DIV;
      r_ff.out_div <= RST_OUT_DIV;
      r_ff.row_lo  <= RST_ROW_LO;
      r_ff.row_hi  <= RST_ROW_HI;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign prdata               = r_ff.prdata;
  assign pready               = r_ff.pready;
  assign pslverr              = r_ff.pslverr;
  assign pll_enable           = r_ff.pll_en;
  assign pll_out_connect      = r_ff.pll_conn;
  assign core_clk_gate        = r_ff.clk_gate;
  assign grst_start           = r_ff.grst_start;
  assign pll_multiplier       = r_ff.mul;
  assign prescale_field       = r_ff.pre;
  assign array_pixel_divider  = r_ff.arr_div;
  assign output_pixel_divider = r_ff.out_div;
  assign row_rate_arr         = r_ff.row_lo;
  assign row_rate_out         = r_ff.row_hi;
endmodule

// ===== test/spm_top_sva.sv
// Assertion checker on the ports of the PLL and mode control block
`timescale 1ns/100ps
module spm_top_sva
  import spm_pkg::*;
#(
  parameter int LOCK_CYC = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        frame_end,
  input wire logic        pll_enable,
  input wire logic        pll_out_connect,
  input wire logic        core_clk_gate,
  input wire logic        grst_start,
  input wire logic [7:0]  pll_multiplier
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles spent with the VCO running but its output still held off
  logic [15:0] lk_ff;
  logic [15:0] nxt_lk;
  always_comb nxt_lk = (pll_enable && !pll_out_connect) ? lk_ff + 16'h1 : 16'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lk_ff <= 16'h0;
    else lk_ff <= nxt_lk;
  end
  chk_lock_delay: assert property (
    $rose(pll_out_connect) |-> lk_ff inside {[LOCK_CYC-1:LOCK_CYC+1]}) else $error("lock delay wrong");
  chk_lock_start: assert property (
    $rose(pll_enable) |-> !pll_out_connect) else $error("output connected at lock start");
  chk_gate_conn: assert property (
    core_clk_gate |-> pll_out_connect) else $error("core clocks run without pll");
  chk_conn_en: assert property (
    pll_out_connect |-> pll_enable) else $error("pll output without pll enable");
  chk_stop_frame: assert property (
    $fell(pll_out_connect) |-> $past(frame_end)) else $error("stream stopped off frame boundary");
  chk_mul_write: assert property (
    $changed(pll_multiplier) |-> $past(psel && penable && pwrite && paddr == OFS_PLL_MUL))
    else $error("multiplier changed without write");
  chk_err_ready: assert property (
    pslverr |-> pready) else $error("error without ready");
  chk_ready_pulse: assert property (
    pready |=> !pready) else $error("ready longer than one cycle");
  chk_grst_pulse: assert property (
    grst_start |=> !grst_start) else $error("trigger pulse too long");
  chk_sysdiv_read: assert property (
    pready && !pwrite && paddr == OFS_SYS_DIV |-> prdata == 32'({OUT_SYS_DIV, ARR_SYS_DIV}))
    else $error("system divider read wrong");
endmodule

bind spm_top spm_top_sva #(.LOCK_CYC(LOCK_CYC)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .frame_end(frame_end), .pll_enable(pll_enable), .pll_out_connect(pll_out_connect),
  .core_clk_gate(core_clk_gate), .grst_start(grst_start), .pll_multiplier(pll_multiplier));

// ===== test/spm_host_model.sv
// Host controller model: APB master and control pin driver
`timescale 1ns/100ps
module spm_host_model (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       gpi_pin,
  output logic             frame_end
);
  // Bus and pins at rest; called by the bench so one process drives every output
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    gpi_pin <= 4'h0;
    frame_end <= 1'b0;
  endtask
  // Request held until ready is seen at a rising edge, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      tb.err_count++;
      tb.final_report();
    end
  endtask
endmodule

// ===== test/tb.sv
// Self-checking bench for the PLL and mode control block
`timescale 1ns/100ps
module tb;
  import spm_pkg::*;
  localparam int LCK = 20;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, frame_end, e;
  logic [7:0]  paddr, mul;
  logic [31:0] pwdata, prdata, q;
  logic [31:0] s = 32'd48;
  logic [3:0]  gpi_pin;
  logic        pll_enable, pll_out_connect, core_clk_gate, grst_start;
  logic [5:0]  pre;
  logic [4:0]  arr, outd;
  logic [2:0]  rlo, rhi;
  int          err_count = 0;
  int          n_tests = 0;
  int          grst_seen = 0;
  int          n, g0, lo;
  int          m[6];
  // Reference clock the host is assumed to drive; bounds the multiplier picks
  localparam int REF_MHZ = 48;
  // Expected divider word, pushed when programmed and popped at the compare
  logic [29:0] dq[$];
  always #20 pclk = ~pclk;
  always @(posedge pclk) if (grst_start === 1'b1) grst_seen <= grst_seen + 1;
  spm_host_model host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .gpi_pin(gpi_pin), .frame_end(frame_end));
  spm_top #(.LOCK_CYC(LCK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpi_pin(gpi_pin), .frame_end(frame_end), .pll_enable(pll_enable), .pll_out_connect(pll_out_connect),
    .core_clk_gate(core_clk_gate), .grst_start(grst_start), .pll_multiplier(mul), .prescale_field(pre),
    .array_pixel_divider(arr), .output_pixel_divider(outd), .row_rate_arr(rlo), .row_rate_out(rhi));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    host.xfer(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk(32'(e), 32'(xe));
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    host.idle();
    cyc(10);
    presetn <= 1'b1;
    cyc(1);
    dq.push_back({RST_PLL_MUL, RST_PRE_DIV, RST_ARR_DIV, RST_OUT_DIV, RST_ROW_LO, RST_ROW_HI});
    chk(32'({mul, pre, arr, outd, rlo, rhi}), 32'(dq.pop_front()));
    rd(OFS_SYS_DIV, 32'({OUT_SYS_DIV, ARR_SYS_DIV}), 1'b0);
    wr(OFS_LIM_VCO, 32'h0);
    rd(OFS_LIM_VCO, {VCO_MAX_MHZ, VCO_MIN_MHZ}, 1'b0);
    rd(OFS_LIM_VCOIN, {VIN_MAX_MHZ, VIN_MIN_MHZ}, 1'b0);
    rd(OFS_LIM_MUL, 32'({MUL_MAX, MUL_MIN}), 1'b0);
    rd(OFS_LIM_PRE, 32'({PRE_MAX, PRE_MIN}), 1'b0);
    rd(8'h3c, 32'h0, 1'b1);
    // Dividers change only in standby; picks keep every host-side range and ratio
    for (int k = 0; k < 4; k++) begin
      m[1] = 3 + xs() % 5;
      lo = VCO_MIN_MHZ * (m[1] + 1) / REF_MHZ;
      m[0] = lo + xs() % (lo + 1);
      m[2] = 1 + xs() % 7;
      // Even passes serial output (quarter rate), odd passes parallel (half rate)
      m[3] = (k % 2 == 0) ? 4 * m[2] : 2 * m[2];
      m[4] = 1 + xs() % 7;
      m[5] = m[4];
      dq.push_back({8'(m[0]), 6'(m[1]), 5'(m[2]), 5'(m[3]), 3'(m[4]), 3'(m[5])});
      wr(OFS_PLL_MUL, m[0]);
      wr(OFS_PRE_DIV, m[1]);
      wr(OFS_PIX_DIV, m[2] | m[3] << PIX_OP_LSB);
      wr(OFS_ROW_RATE, m[4] | m[5] << ROW_OP_LSB);
      cyc(1);
      chk(32'({mul, pre, arr, outd, rlo, rhi}), 32'(dq.pop_front()));
    end
    // Lock wait scaled to the simulation lock count
    cyc(LCK);
    wr(OFS_MODE_CTRL, 32'h1 << STREAM_BIT);
    cyc(2);
    chk(pll_enable, 1'b1);
    for (n = 0; n < 200 && pll_out_connect !== 1'b1; n++) @(posedge pclk);
    if (n == 200) begin
      err_count++;
      final_report();
    end
    chk(32'(n >= LCK - 4 && n <= LCK + 1), 32'h1);
    chk(core_clk_gate, 1'b1);
    wr(OFS_MODE_CTRL, 32'h0);
    cyc(10);
    chk(pll_out_connect, 1'b1);
    // Waiting for frame end: clock gate, connect and enable set, state code 3
    rd(OFS_STATUS, 32'h1f, 1'b0);
    host.frame_end <= 1'b1;
    cyc(1);
    host.frame_end <= 1'b0;
    cyc(2);
    chk({pll_enable, core_clk_gate}, 2'b00);
    wr(OFS_PIN_SEL, 32'h1 << SEL_STBY_LSB);
    host.gpi_pin <= 4'hf;
    wr(OFS_MODE_CTRL, 32'h1 << STREAM_BIT);
    cyc(5);
    chk(pll_enable, 1'b1);
    wr(OFS_MODE_CTRL, 32'h0);
    cyc(2);
    chk(pll_enable, 1'b0);
    wr(OFS_MODE_CTRL, 32'h1 << STREAM_BIT | 32'h1 << GPI_EN_BIT);
    cyc(8);
    chk(pll_enable, 1'b0);
    host.gpi_pin <= 4'he;
    cyc(6);
    chk(pll_enable, 1'b1);
    host.gpi_pin <= 4'h1;
    cyc(6);
    chk(pll_enable, 1'b0);
    wr(OFS_MODE_CTRL, 32'h1 << GPI_EN_BIT);
    g0 = grst_seen;
    wr(OFS_TRIG_CTRL, 32'h1 << GRST_EN_BIT);
    cyc(5);
    chk(grst_seen, g0);
    wr(OFS_TRIG_CTRL, 32'h3);
    cyc(4);
    chk(grst_seen, g0 + 1);
    wr(OFS_TRIG_CTRL, 32'h2);
    wr(OFS_PIN_SEL, 32'h2 << SEL_TRIG_LSB);
    host.gpi_pin <= 4'h2;
    cyc(6);
    chk(grst_seen, g0 + 2);
    rd(OFS_GPI_STATUS, 32'h2, 1'b0);
    final_report();
  end
endmodule
